// >>> verilog/sfcd_regs.vh
`ifndef SFCD_REGS_VH
`define SFCD_REGS_VH
// Instruction codes.
`define SFCD_OP_RDSTAT 8'h05
`define SFCD_OP_ARM 8'h06
`define SFCD_OP_DISARM 8'h04
`define SFCD_OP_STWR 8'h01
`define SFCD_OP_PAGE 8'h02
`define SFCD_OP_SECT 8'h20
`define SFCD_OP_BLK32 8'h52
`define SFCD_OP_BLK64 8'hd8
`define SFCD_OP_CHIPA 8'hc7
`define SFCD_OP_CHIPB 8'h60
`define SFCD_OP_UID 8'h4b
`define SFCD_OP_READ 8'h03
`define SFCD_OP_FAST 8'h0b
`define SFCD_OP_DUAL 8'h3b
`define SFCD_OP_SLEEP 8'hb9
`define SFCD_OP_WAKE 8'hab
`define SFCD_OP_LEGID 8'h90
`define SFCD_OP_STDID 8'h9f
// Status bit positions.
`define SFCD_SR_BUSY 0
`define SFCD_SR_ARM 1
// Status write mask: lock bit 7 and guard bits 4:2.
`define SFCD_SR_WMASK 8'h9c
// Byte counts within an instruction.
`define SFCD_ADDR_END 3'h3
`define SFCD_DUMMY_END 3'h4
`define SFCD_PAGE_MASK 24'h0000ff
// Operation kinds sent to the array.
`define SFCD_K_STWR 3'h0
`define SFCD_K_PAGE 3'h1
`define SFCD_K_SECT 3'h2
`define SFCD_K_BLK32 3'h3
`define SFCD_K_BLK64 3'h4
`define SFCD_K_CHIP 3'h5
`endif

// >>> verilog/sfcd_edge_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser for the serial pins with edge detection on the clean copy.
module sfcd_edge_sync (
  input wire coreClk,
  input wire rstN,
  input wire pinIn,
  output reg syncOut,
  output wire rise,
  output wire fall
);
  reg meta_reg;
  reg last_reg;

  // The first flop feeds only the second, to contain metastability.
  always @(posedge coreClk or negedge rstN) begin
    if (!rstN) begin
      meta_reg <= 1'b0;
      syncOut <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pinIn;
      syncOut <= meta_reg;
      last_reg <= syncOut;
    end
  end

  // Edges are seen in the same core cycle as the synchronised level changes.
  assign rise = syncOut & ~last_reg;
  assign fall = ~syncOut & last_reg;
endmodule

// >>> verilog/sfcd_decoder.v
`timescale 1ns/1ps
`include "sfcd_regs.vh"
module sfcd_decoder #(
  parameter MAKER_ID = 8'ha5, // Arbitrary identity value.
  parameter DEVICE_ID = 8'h3c, // Arbitrary identity value.
  parameter MEM_TYPE = 8'h4d, // Arbitrary identity value.
  parameter CAP_CODE = 8'h2e, // Arbitrary identity value.
  parameter [127:0] UNIQUE_ID = 128'h0123456789abcdef0f1e2d3c4b5a6978 // Arbitrary.
) (
  input wire core_clk,
  input wire nrst,
  input wire serialClk,
  input wire selectN,
  input wire serial_in_pin,
  output reg serialOut,
  output reg serialOutEn,
  output reg dual_lane_zero,
  output reg dualLaneZeroEn,
  output reg [23:0] memAddr,
  output reg memRead,
  input wire [7:0] memRdData,
  output reg [7:0] memWrData,
  output reg memWrite,
  output reg [2:0] opKind,
  output reg opStart,
  input wire opDone,
  output reg activeMode,
  output reg sleepMode,
  output reg [7:0] statusByte
);
  reg rstMeta_reg;
  reg rstN;
  wire clkSync;
  wire clkRise;
  wire clkFall;
  wire selSync;
  wire selRise;
  wire selFall;
  wire dinSync;
  reg [7:0] shift_reg;
  reg [2:0] bitCnt_reg;
  reg [2:0] byteCnt_reg;
  reg [7:0] opcode_reg;
  reg opValid_reg;
  reg [23:0] addr_reg;
  reg [7:0] dataOut_reg;
  reg [6:0] uidBit_reg;
  reg [1:0] idIdx_reg;
  reg busy_reg;
  reg arm_reg;
  reg [7:0] guard_reg;
  reg byteDone;
  reg [7:0] byteIn;
  reg [7:0] pendData_reg;
  reg pendValid_reg;
  reg fetch_reg;

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_reg <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstN <= rstMeta_reg;
    end
  end

  // Pin synchronisers; clock edges come from sampling the serial clock.
  sfcd_edge_sync uClk (.coreClk(core_clk), .rstN(rstN), .pinIn(serialClk),
    .syncOut(clkSync), .rise(clkRise), .fall(clkFall));
  sfcd_edge_sync uSel (.coreClk(core_clk), .rstN(rstN), .pinIn(~selectN),
    .syncOut(selSync), .rise(selFall), .fall(selRise));
  sfcd_edge_sync uDin (.coreClk(core_clk), .rstN(rstN), .pinIn(serial_in_pin),
    .syncOut(dinSync), .rise(), .fall());

  ////////////////////////////////////////////////////////////////////////
  // Functions used by several decisions.
  function isWriteOp;
    input [7:0] op;
    begin
      isWriteOp = (op == `SFCD_OP_STWR) || (op == `SFCD_OP_PAGE) ||
        (op == `SFCD_OP_SECT) || (op == `SFCD_OP_BLK32) ||
        (op == `SFCD_OP_BLK64) || (op == `SFCD_OP_CHIPA) || (op == `SFCD_OP_CHIPB);
    end
  endfunction

  function [2:0] kindOf;
    input [7:0] op;
    begin
      case (op)
        `SFCD_OP_STWR: kindOf = `SFCD_K_STWR;
        `SFCD_OP_PAGE: kindOf = `SFCD_K_PAGE;
        `SFCD_OP_SECT: kindOf = `SFCD_K_SECT;
        `SFCD_OP_BLK32: kindOf = `SFCD_K_BLK32;
        `SFCD_OP_BLK64: kindOf = `SFCD_K_BLK64;
        default: kindOf = `SFCD_K_CHIP;
      endcase
    end
  endfunction

  // Byte index within the unique identifier, MSB byte first.
  function [7:0] uidByte;
    input [3:0] idx;
    begin
      uidByte = UNIQUE_ID[8'd127 - {idx, 3'h0} -: 8];
    end
  endfunction

  // Completed byte on this rising edge, MSB first.
  always @* begin
    byteIn = {shift_reg[6:0], dinSync};
    byteDone = clkRise && selSync && (bitCnt_reg == 3'h7);
  end

  ////////////////////////////////////////////////////////////////////////
  // Input shifting, opcode capture and the data-out byte selection.
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      shift_reg <= 8'h00;
      bitCnt_reg <= 3'h0;
      byteCnt_reg <= 3'h0;
      opcode_reg <= 8'h00;
      opValid_reg <= 1'b0;
      addr_reg <= 24'h000000;
      dataOut_reg <= 8'h00;
      uidBit_reg <= 7'h00;
      idIdx_reg <= 2'h0;
      memRead <= 1'b0;
      memWrite <= 1'b0;
      memWrData <= 8'h00;
      memAddr <= 24'h000000;
      pendData_reg <= 8'h00;
      pendValid_reg <= 1'b0;
      fetch_reg <= 1'b0;
    end else begin
      memRead <= 1'b0;
      memWrite <= 1'b0;
      fetch_reg <= 1'b0;
      // The array address landed last cycle, so its data is valid only now.
      if (fetch_reg) begin
        dataOut_reg <= memRdData;
        memAddr <= memAddr + 24'h000001;
        memRead <= 1'b1;
      end
      if (selFall) begin
        // A new instruction starts here.
        bitCnt_reg <= 3'h0;
        byteCnt_reg <= 3'h0;
        opValid_reg <= 1'b0;
        pendValid_reg <= 1'b0;
        uidBit_reg <= 7'h00;
        idIdx_reg <= 2'h0;
      end else if (clkRise && selSync) begin
        shift_reg <= byteIn;
        bitCnt_reg <= bitCnt_reg + 3'h1;
        if (byteDone) begin
          if (byteCnt_reg != 3'h7) begin
            byteCnt_reg <= byteCnt_reg + 3'h1;
          end
          if (!opValid_reg) begin
            opcode_reg <= byteIn;
            opValid_reg <= 1'b1;
            if (byteIn == `SFCD_OP_RDSTAT) begin
              dataOut_reg <= statusByte;
            end else if (byteIn == `SFCD_OP_STDID) begin
              dataOut_reg <= MAKER_ID;
              idIdx_reg <= 2'h1;
            end
          end else if (byteCnt_reg <= `SFCD_ADDR_END) begin
            addr_reg <= {addr_reg[15:0], byteIn};
            if (opcode_reg == `SFCD_OP_STWR && !busy_reg) begin
              pendData_reg <= byteIn;
              pendValid_reg <= 1'b1;
            end
            if (byteCnt_reg == `SFCD_ADDR_END) begin
              case (opcode_reg)
                `SFCD_OP_READ: begin
                  // Read data lags the address by a cycle; fetch it before the first fall.
                  fetch_reg <= !busy_reg && !sleepMode;
                  memAddr <= {addr_reg[15:0], byteIn};
                end
                `SFCD_OP_LEGID:
                  dataOut_reg <= byteIn[0] ? DEVICE_ID : MAKER_ID;
                `SFCD_OP_WAKE:
                  dataOut_reg <= DEVICE_ID;
                default:
                  memAddr <= {addr_reg[15:0], byteIn};
              endcase
            end
          end else if (opcode_reg == `SFCD_OP_PAGE) begin
            // Data byte goes to the page buffer; address wraps in the page.
            memWrData <= byteIn;
            memWrite <= !busy_reg && arm_reg && !sleepMode;
            memAddr <= addr_reg;
            addr_reg <= (addr_reg & ~`SFCD_PAGE_MASK) |
              ((addr_reg + 24'h000001) & `SFCD_PAGE_MASK);
          end else if (byteCnt_reg == `SFCD_DUMMY_END) begin
            if (opcode_reg == `SFCD_OP_UID) begin
              dataOut_reg <= uidByte(4'h0);
            end
          end
        end
      end else if (clkFall && selSync && opValid_reg && ((opcode_reg == `SFCD_OP_DUAL &&
        byteCnt_reg > `SFCD_DUMMY_END) ? (bitCnt_reg[1:0] == 2'h3) : (bitCnt_reg == 3'h7))) begin
        // Load the next byte as the last bit of this one goes out, so the
        // following fall already shifts the new most significant bit.
        case (opcode_reg)
          `SFCD_OP_RDSTAT: dataOut_reg <= statusByte;
          `SFCD_OP_WAKE: dataOut_reg <= DEVICE_ID;
          `SFCD_OP_STDID: begin
            dataOut_reg <= (idIdx_reg == 2'h1) ? MEM_TYPE : CAP_CODE;
            idIdx_reg <= (idIdx_reg == 2'h3) ? 2'h3 : idIdx_reg + 2'h1;
          end
          `SFCD_OP_LEGID:
            dataOut_reg <= (dataOut_reg == MAKER_ID) ? DEVICE_ID : MAKER_ID;
          `SFCD_OP_UID: begin
            if (byteCnt_reg > `SFCD_DUMMY_END) begin
              uidBit_reg <= uidBit_reg + 7'h08;
              dataOut_reg <= uidByte(uidBit_reg[6:3] + 4'h1);
            end
          end
          default: begin
            if (byteCnt_reg > `SFCD_ADDR_END && !busy_reg && !sleepMode &&
              (opcode_reg == `SFCD_OP_READ || opcode_reg == `SFCD_OP_FAST ||
               opcode_reg == `SFCD_OP_DUAL)) begin
              memAddr <= memAddr + 24'h000001;
              memRead <= 1'b1;
              dataOut_reg <= memRdData;
            end
          end
        endcase
      end else if (clkFall && selSync && !opValid_reg && bitCnt_reg == 3'h0) begin
        memRead <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status, arm latch, busy, sleep and operation launch at select rise.
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      busy_reg <= 1'b0;
      arm_reg <= 1'b0;
      guard_reg <= 8'h00;
      sleepMode <= 1'b0;
      opStart <= 1'b0;
      opKind <= 3'h0;
    end else begin
      opStart <= 1'b0;
      if (busy_reg && opDone) begin
        busy_reg <= 1'b0;
        arm_reg <= 1'b0;
        if (opKind == `SFCD_K_STWR) begin
          guard_reg <= (guard_reg & ~`SFCD_SR_WMASK) |
            (pendData_reg & `SFCD_SR_WMASK);
        end
      end else if (selRise && opValid_reg) begin
        if (sleepMode) begin
          if (opcode_reg == `SFCD_OP_WAKE) begin
            sleepMode <= 1'b0;
          end
        end else if (!busy_reg) begin
          if (bitCnt_reg == 3'h0) begin
            case (opcode_reg)
              `SFCD_OP_ARM: arm_reg <= 1'b1;
              `SFCD_OP_DISARM: arm_reg <= 1'b0;
              `SFCD_OP_SLEEP: sleepMode <= 1'b1;
              default: begin
                // Write kinds need the latch, whole bytes and full length; a page program launches after its address alone, with no data byte.
                if (isWriteOp(opcode_reg) && arm_reg &&
                  ((opcode_reg == `SFCD_OP_STWR && pendValid_reg) ||
                   (opcode_reg == `SFCD_OP_PAGE && byteCnt_reg > `SFCD_ADDR_END + 3'h1) ||
                   (opcode_reg == `SFCD_OP_CHIPA) || (opcode_reg == `SFCD_OP_CHIPB) ||
                   (byteCnt_reg > `SFCD_ADDR_END))) begin
                  busy_reg <= 1'b1;
                  opStart <= 1'b1;
                  opKind <= kindOf(opcode_reg);
                end
              end
            endcase
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial output on falling clock; released at select rise.
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
      dual_lane_zero <= 1'b0;
      dualLaneZeroEn <= 1'b0;
    end else if (!selSync) begin
      serialOutEn <= 1'b0;
      dualLaneZeroEn <= 1'b0;
    end else if (clkFall && opValid_reg && !(sleepMode && opcode_reg != `SFCD_OP_WAKE) &&
      !(busy_reg && opcode_reg != `SFCD_OP_RDSTAT)) begin
      // Reads hold the shared data register; the bit index walks MSB first.
      if (opcode_reg == `SFCD_OP_DUAL && byteCnt_reg > `SFCD_DUMMY_END) begin
        serialOut <= dataOut_reg[{~bitCnt_reg[1:0], 1'b1}];
        dual_lane_zero <= dataOut_reg[{~bitCnt_reg[1:0], 1'b0}];
        serialOutEn <= 1'b1;
        dualLaneZeroEn <= 1'b1;
      end else begin
        serialOut <= dataOut_reg[3'h7 - bitCnt_reg];
        serialOutEn <= 1'b1;
      end
    end
  end

  // Status byte and mode outputs.
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      statusByte <= 8'h00;
      activeMode <= 1'b0;
    end else begin
      statusByte <= (guard_reg & `SFCD_SR_WMASK) | {6'h00, arm_reg, busy_reg};
      activeMode <= selSync | busy_reg;
    end
  end
endmodule

// >>> bench/sfcd_props.sv
`timescale 1ns/1ps
// Pin-level checks on select framing, cycle launch and sleep gating.
module sfcd_props (
  input wire core_clk,
  input wire nrst,
  input wire selectN,
  input wire serialOutEn,
  input wire dualLaneZeroEn,
  input wire memRead,
  input wire memWrite,
  input wire opStart,
  input wire opDone,
  input wire activeMode,
  input wire sleepMode,
  input wire [7:0] statusByte
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Eight quiet cycles cover the select synchroniser and the output register.
  sequence s_idle;
    selectN [*8];
  endsequence
  sequence s_busy;
    ##[0:2] statusByte[0];
  endsequence
  sequence s_clear;
    ##[1:3] (!statusByte[0] && !statusByte[1]);
  endsequence
  a_idle_quiet: assert property (s_idle |-> !serialOutEn && !dualLaneZeroEn)
    else $error("output driven while deselected");
  a_select_active: assert property ($fell(selectN) && !sleepMode |-> ##[1:6] activeMode)
    else $error("select low without active mode");
  a_busy_set: assert property (opStart |-> s_busy)
    else $error("cycle launched without busy flag");
  a_busy_hold: assert property (statusByte[0] && !opDone && !$past(opDone) |=> statusByte[0])
    else $error("busy flag dropped before cycle end");
  a_done_clear: assert property (opDone && statusByte[0] |-> s_clear)
    else $error("busy or arm latch left set after cycle end");
  a_armed_start: assert property (opStart |-> statusByte[1])
    else $error("cycle launched without arm latch");
  a_idle_start: assert property (opStart |-> !$past(statusByte[0]))
    else $error("cycle launched while busy");
  a_sleep_gate: assert property (sleepMode |-> !opStart && !memWrite && !memRead)
    else $error("array touched in deep power-down");
endmodule
bind sfcd_decoder sfcd_props u_props (.core_clk(core_clk), .nrst(nrst), .selectN(selectN),
  .serialOutEn(serialOutEn), .dualLaneZeroEn(dualLaneZeroEn), .memRead(memRead),
  .memWrite(memWrite), .opStart(opStart), .opDone(opDone), .activeMode(activeMode),
  .sleepMode(sleepMode), .statusByte(statusByte));

// >>> bench/sfcd_host_model.sv
`timescale 1ns/1ps
// Host end of the link in mode 0; the clock stands low between frames.
module sfcd_host_model (
  output reg serialClk,
  output reg selectN,
  output reg serial_in_pin,
  input wire serialOut,
  input wire dual_lane_zero
);
  reg [7:0] txq[$];
  reg [7:0] rxq[$];
  reg [7:0] r;
  initial begin
    serialClk = 1'b0;
    selectN = 1'b1;
    serial_in_pin = 1'b0;
  end
  // Data is set while the clock is low so it is settled at the rise.
  task bit1(input b, input dl);
    begin
      serial_in_pin = b;
      #80 serialClk = 1'b1;
      r = dl ? {r[5:0], serialOut, dual_lane_zero} : {r[6:0], serialOut};
      #80 serialClk = 1'b0;
    end
  endtask
  // Sends the queued bytes, xb loose bits, then reads rd bytes.
  task run(input integer rd, input integer xb, input dl);
    integer i;
    integer k;
    reg [7:0] t;
    begin
      rxq.delete();
      selectN = 1'b0;
      #80;
      while (txq.size() > 0) begin
        t = txq.pop_front();
        for (k = 7; k >= 0; k = k - 1) bit1(t[k], 1'b0);
      end
      for (k = 0; k < xb; k = k + 1) bit1(1'b1, 1'b0);
      for (i = 0; i < rd; i = i + 1) begin
        for (k = 0; k < (dl ? 4 : 8); k = k + 1) bit1(~serial_in_pin, dl);
        rxq.push_back(r);
      end
      #80 selectN = 1'b1;
      // A released line must not keep its last level.
      serial_in_pin = ~serial_in_pin;
      #800;
    end
  endtask
endmodule

// >>> bench/serial_flash_command_decoder_tb.sv
`timescale 1ns/1ps
`include "sfcd_regs.vh"
module serial_flash_command_decoder_tb;
  localparam [127:0] UID = 128'h8e7d6c5b4a39281706f5e4d3c2b1a098; // Arbitrary value.
  localparam [7:0] MK = 8'h6b, DV = 8'h27, MT = 8'h91, CP = 8'h1d; // Arbitrary values.
  localparam [39:0] EOPS = {`SFCD_OP_SECT, `SFCD_OP_BLK32, `SFCD_OP_BLK64, `SFCD_OP_CHIPA,
    `SFCD_OP_CHIPB};
  localparam [14:0] EKND = {`SFCD_K_SECT, `SFCD_K_BLK32, `SFCD_K_BLK64, `SFCD_K_CHIP, `SFCD_K_CHIP};
  reg core_clk = 1'b0;
  reg nrst = 1'b0;
  reg opDone = 1'b0;
  reg [2:0] lastKind = 3'h0;
  reg [10:0] doneCnt = 11'h000;
  reg [23:0] a;
  reg [7:0] e;
  reg [31:0] wrq[$];
  wire serialClk, selectN, serial_in_pin, serialOut, serialOutEn, dual_lane_zero, dualLaneZeroEn;
  wire memRead, memWrite, opStart, activeMode, sleepMode;
  wire [23:0] memAddr;
  wire [7:0] memWrData, statusByte;
  wire [2:0] opKind;
  integer err_count = 0, checks_done = 0, starts = 0, rdPulses = 0, i, k, seed;
  function [7:0] md(input [23:0] x);
    md = x[7:0] ^ x[15:8] ^ 8'h5a;
  endfunction
  wire [7:0] memRdData = md(memAddr);
  sfcd_decoder #(.MAKER_ID(MK), .DEVICE_ID(DV), .MEM_TYPE(MT), .CAP_CODE(CP), .UNIQUE_ID(UID)) uut (
    .core_clk(core_clk), .nrst(nrst), .serialClk(serialClk), .selectN(selectN),
    .serial_in_pin(serial_in_pin), .serialOut(serialOut), .serialOutEn(serialOutEn),
    .dual_lane_zero(dual_lane_zero), .dualLaneZeroEn(dualLaneZeroEn), .memAddr(memAddr),
    .memRead(memRead), .memRdData(memRdData), .memWrData(memWrData), .memWrite(memWrite),
    .opKind(opKind), .opStart(opStart), .opDone(opDone), .activeMode(activeMode),
    .sleepMode(sleepMode), .statusByte(statusByte));
  sfcd_host_model host (.serialClk(serialClk), .selectN(selectN), .serial_in_pin(serial_in_pin),
    .serialOut(serialOut), .dual_lane_zero(dual_lane_zero));
  always #4 core_clk = ~core_clk;
  // Array stand-in: long enough cycles that a status poll lands inside one.
  always @(posedge core_clk) begin
    opDone <= doneCnt == 11'd1;
    if (doneCnt != 11'd0) doneCnt <= doneCnt - 11'd1;
    if (opStart) begin
      doneCnt <= 11'd1500;
      starts <= starts + 1;
      lastKind <= opKind;
    end
    if (memWrite) wrq.push_back({memAddr, memWrData});
    if (memRead) rdPulses <= rdPulses + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Sends n bytes, right aligned in v, as one frame.
  task op(input [63:0] v, input integer n, input integer rd, input integer xb, input dl);
    integer j;
    begin
      for (j = n - 1; j >= 0; j = j - 1) host.txq.push_back(v[8*j +: 8]);
      host.run(rd, xb, dl);
    end
  endtask
  task rdsr(input [7:0] x);
    begin
      op(`SFCD_OP_RDSTAT, 1, 2, 0, 0);
      chk(host.rxq[0], x);
      chk(host.rxq[1], x);
    end
  endtask
  task idle;
    integer j;
    begin
      for (j = 0; j < 3000 && statusByte[0] !== 1'b0; j = j + 1) @(posedge core_clk);
      #1000;
    end
  endtask
  task complete_run;
    begin
      $display("Checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // Watchdog sized well above the roughly 38k cycles the sequence needs.
  initial begin
    #800000;
    err_count = err_count + 1;
    complete_run;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = $urandom(78);
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge core_clk);
    rdsr(8'h00);
    op(`SFCD_OP_ARM, 1, 0, 0, 0);
    rdsr(8'h02);
    op(`SFCD_OP_DISARM, 1, 0, 0, 0);
    rdsr(8'h00);
    op({`SFCD_OP_SECT, 24'h001000}, 4, 0, 0, 0);
    chk(starts, 0);
    // Every erase code, each polled and poked with a write-disable while busy.
    for (i = 0; i < 5; i = i + 1) begin
      a = 24'($urandom);
      e = EOPS[39-8*i -: 8];
      op(`SFCD_OP_ARM, 1, 0, 0, 0);
      op(i < 3 ? {e, a} : e, i < 3 ? 4 : 1, 0, 0, 0);
      rdsr(8'h03);
      op(`SFCD_OP_DISARM, 1, 0, 0, 0);
      rdsr(8'h03);
      idle;
      chk(lastKind, EKND[14-3*i -: 3]);
      rdsr(8'h00);
    end
    op(`SFCD_OP_ARM, 1, 0, 0, 0);
    op({`SFCD_OP_SECT, a}, 4, 0, 3, 0);
    idle;
    chk(starts, 5);
    rdsr(8'h02);
    a = {a[23:8], 8'hfe};
    k = $urandom;
    op({`SFCD_OP_PAGE, a, k[23:0]}, 7, 0, 0, 0);
    idle;
    chk(lastKind, `SFCD_K_PAGE);
    chk(wrq.size(), 3);
    for (i = 0; i < 3; i = i + 1) chk(wrq[i], {a[23:8], a[7:0] + i[7:0], k[23-8*i -: 8]});
    for (i = 0; i < 3; i = i + 1) begin
      a = 24'($urandom);
      case (i)
        0: op({`SFCD_OP_READ, a}, 4, 3, 0, 0);
        1: op({`SFCD_OP_FAST, a, 8'h00}, 5, 3, 0, 0);
        default: op({`SFCD_OP_DUAL, a, 8'h00}, 5, 3, 0, 1);
      endcase
      for (k = 0; k < 3; k = k + 1) chk(host.rxq[k], md(a + k[23:0]));
      if (i == 0) chk(rdPulses, 4);
    end
    op({`SFCD_OP_UID, a, 8'h00}, 5, 16, 0, 0);
    for (k = 0; k < 16; k = k + 1) chk(host.rxq[k], UID[127-8*k -: 8]);
    op(`SFCD_OP_STDID, 1, 3, 0, 0);
    chk({host.rxq[0], host.rxq[1], host.rxq[2]}, {MK, MT, CP});
    op({`SFCD_OP_LEGID, 24'h000000}, 4, 2, 0, 0);
    chk({host.rxq[0], host.rxq[1]}, {MK, DV});
    op({`SFCD_OP_LEGID, 24'h000001}, 4, 2, 0, 0);
    chk({host.rxq[0], host.rxq[1]}, {DV, MK});
    op(`SFCD_OP_SLEEP, 1, 0, 0, 0);
    chk(sleepMode, 1'b1);
    op(`SFCD_OP_ARM, 1, 0, 0, 0);
    op({`SFCD_OP_WAKE, 24'h000000}, 4, 2, 0, 0);
    chk({host.rxq[0], host.rxq[1]}, {DV, DV});
    chk(sleepMode, 1'b0);
    rdsr(8'h00);
    op(`SFCD_OP_ARM, 1, 0, 0, 0);
    op({`SFCD_OP_STWR, 8'hff}, 2, 0, 0, 0);
    idle;
    chk(lastKind, `SFCD_K_STWR);
    rdsr(`SFCD_SR_WMASK);
    complete_run;
  end
endmodule
